// ===== hw/acam_pkg.sv
// Package of constants and types for the converter code alarm monitor
package acam_pkg;
    // Result code width and number of codes across full scale
    localparam int CODE_W = 16;
    localparam int CODE_STEPS = 65536;
    // Number of converter channels
    localparam int NUM_CH = 4;
    // Channel index width
    localparam int CH_W = 2;
    // Serial clock falling edge on which the alarm output may move
    localparam logic [5:0] ALARM_EDGE = 6'h10;
    // Reset values
    localparam logic [15:0] THRESH_RST = 16'h0000;
    localparam logic [15:0] HYST_RST = 16'h0000;
    // Reference source after strap decode
    typedef enum logic {ACAM_REF_INTERNAL, ACAM_REF_EXTERNAL} acam_ref_t;
    // Frame sequencer states
    typedef enum logic [1:0] {ACAM_IDLE, ACAM_FRAME, ACAM_DONE} acam_state_t;
endpackage : acam_pkg

// ===== hw/acam_chan_alarm.sv
// One channel's high and low alarm flags with hysteresis
`timescale 1ns/10ps
module acam_chan_alarm #(
    parameter int W = 16
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic eval,
    input wire logic [W-1:0] code,
    input wire logic [W-1:0] hi_thresh,
    input wire logic [W-1:0] hi_hyst,
    input wire logic [W-1:0] lo_thresh,
    input wire logic [W-1:0] lo_hyst,
    output logic hi_flag_q,
    output logic lo_flag_q
);
    // Bounds widened by two bits so sums and differences never wrap
    logic signed [W+1:0] code_x, hi_set, hi_clr, lo_set, lo_clr;
    logic hi_flag_d, lo_flag_d;

    // Unsigned compare limits, evaluated in a wider signed space
    always_comb begin
        code_x = signed'({2'b00, code});
        hi_set = signed'({2'b00, hi_thresh}) + signed'({2'b00, hi_hyst});
        hi_clr = signed'({2'b00, hi_thresh}) - signed'({2'b00, hi_hyst}) - (W+2)'(2);
        lo_set = signed'({2'b00, lo_thresh}) - signed'({2'b00, lo_hyst}) - (W+2)'(1);
        lo_clr = signed'({2'b00, lo_thresh}) + signed'({2'b00, lo_hyst}) + (W+2)'(1);
        hi_flag_d = hi_flag_q;
        lo_flag_d = lo_flag_q;
        // Only a fresh result re-evaluates; flags hold otherwise
        if (eval) begin
            // High alarm: set above T+H, clear at or below T-H-2
            if (code_x > hi_set) begin
                hi_flag_d = 1'b1;
            end else if (code_x <= hi_clr) begin
                hi_flag_d = 1'b0;
            end
            // Low alarm: set below T-H-1, clear at T+H+1 or above
            if (code_x < lo_set) begin
                lo_flag_d = 1'b1;
            end else if (code_x >= lo_clr) begin
                lo_flag_d = 1'b0;
            end
        end
    end

    // Flag registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hi_flag_q <= 1'b0;
            lo_flag_q <= 1'b0;
        end else begin
            hi_flag_q <= hi_flag_d;
            lo_flag_q <= lo_flag_d;
        end
    end
endmodule : acam_chan_alarm

// ===== hw/acam_monitor.sv
// Result-side alarm monitor of a multi-channel converter
// Contract
// - Results are 16-bit unsigned straight binary.
// - Code zero is negative full scale, linear.
// - Alarm output high when any flag set.
// - Alarm output moves only on 16th falling edge.
// - Each channel has high and low alarms.
// - High sets above T+H, clears at T-H-2.
// - Low sets below T-H-1, clears at T+H+1.
// - Host programs thresholds and hysteresis; device applies.
// - Strap low internal reference, high external.
// - Chip-select fall starts frame and conversion.
`timescale 1ns/10ps
module acam_monitor #(
    parameter int NCH = acam_pkg::NUM_CH,
    parameter int W = acam_pkg::CODE_W
) (
    input wire logic ref_clk,
    input wire logic rstn,
    // Serial link pins, asynchronous to ref_clk
    input wire logic sclk,
    input wire logic cs_n,
    // Channel chosen by the previous frame
    input wire logic [acam_pkg::CH_W-1:0] next_channel,
    // Converter core result, same clock domain
    input wire logic result_valid,
    input wire logic [W-1:0] result_code,
    // Threshold and hysteresis values from the serial port registers
    input wire logic [NCH*W-1:0] hi_thresh,
    input wire logic [NCH*W-1:0] hi_hyst,
    input wire logic [NCH*W-1:0] lo_thresh,
    input wire logic [NCH*W-1:0] lo_hyst,
    // Reference strap pin
    input wire logic reference_source_strap,
    // Conversion start pulse and channel to sample
    output logic conv_start,
    output logic [acam_pkg::CH_W-1:0] conv_channel,
    // Last result, straight binary
    output logic [W-1:0] result_out,
    // Alarm flags for the host to read
    output logic [NCH-1:0] hi_flags,
    output logic [NCH-1:0] lo_flags,
    // Shared alarm pin
    output logic alarm,
    // Reference control: external mode makes the reference pin an input
    output logic ref_external,
    output logic reference_voltage_pin_oe
);
    // Two-flop synchronisers for the link pins and the strap
    // Stage three of each link chain only delays for edge detection
    logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic strap_s1_q, strap_s2_q;
    logic sclk_s1_d, sclk_s2_d, sclk_s3_d, cs_s1_d, cs_s2_d, cs_s3_d;
    logic strap_s1_d, strap_s2_d;

    // Next values of the sync chains
    always_comb begin
        sclk_s1_d = sclk;
        sclk_s2_d = sclk_s1_q;
        sclk_s3_d = sclk_s2_q;
        cs_s1_d = cs_n;
        cs_s2_d = cs_s1_q;
        cs_s3_d = cs_s2_q;
        strap_s1_d = reference_source_strap;
        strap_s2_d = strap_s1_q;
    end

    // Sync chain registers; clock stages reset low, so a pin idling high
    // shows only a harmless rise after reset, never a false fall
    // Select stages reset high (idle) so reset never looks like a frame start
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
        end else begin
            sclk_s1_q <= sclk_s1_d;
            sclk_s2_q <= sclk_s2_d;
            sclk_s3_q <= sclk_s3_d;
            cs_s1_q <= cs_s1_d;
            cs_s2_q <= cs_s2_d;
            cs_s3_q <= cs_s3_d;
            strap_s1_q <= strap_s1_d;
            strap_s2_q <= strap_s2_d;
        end
    end

    // Edge detects look only at synchronised stages
    logic sclk_fall, cs_fall, cs_high;
    assign sclk_fall = sclk_s3_q & ~sclk_s2_q;
    assign cs_fall = cs_s3_q & ~cs_s2_q;
    assign cs_high = cs_s2_q;

    // Frame sequencer, falling-edge counter and output state
    acam_pkg::acam_state_t state_q, state_d;
    // Six bits leave room past the 16th fall; counting stops there
    logic [5:0] edge_cnt_q, edge_cnt_d;
    // Start pulse lasts one clock; channel holds for the whole frame
    logic conv_start_q, conv_start_d;
    logic [acam_pkg::CH_W-1:0] conv_ch_q, conv_ch_d;
    logic [W-1:0] result_q, result_d;
    logic alarm_q, alarm_d;
    logic [NCH-1:0] hi_f, lo_f;
    logic any_flag;
    logic [NCH-1:0] ch_eval;

    // Any channel flag drives the pin level
    assign any_flag = |{hi_f, lo_f};

    always_comb begin
        state_d = state_q;
        edge_cnt_d = edge_cnt_q;
        conv_start_d = 1'b0;
        conv_ch_d = conv_ch_q;
        result_d = result_q;
        alarm_d = alarm_q;
        // Result passes through unchanged: straight binary code
        if (result_valid) begin
            result_d = result_code;
        end
        case (state_q)
            acam_pkg::ACAM_IDLE: begin
                // Frame opens on chip-select fall; sample prior channel
                if (cs_fall) begin
                    state_d = acam_pkg::ACAM_FRAME;
                    edge_cnt_d = 6'h00;
                    conv_start_d = 1'b1;
                    conv_ch_d = next_channel;
                end
            end
            acam_pkg::ACAM_FRAME: begin
                // Select rising early aborts the frame; alarm keeps its level
                if (cs_high) begin
                    state_d = acam_pkg::ACAM_IDLE;
                end else if (sclk_fall) begin
                    edge_cnt_d = edge_cnt_q + 6'h01;
                    // Alarm pin only updates on the 16th fall
                    if (edge_cnt_q + 6'h01 == acam_pkg::ALARM_EDGE) begin
                        alarm_d = any_flag;
                        state_d = acam_pkg::ACAM_DONE;
                    end
                end
            end
            acam_pkg::ACAM_DONE: begin
                // Rest of frame ignored until chip select rises
                if (cs_high) begin
                    state_d = acam_pkg::ACAM_IDLE;
                end
            end
            default: state_d = acam_pkg::ACAM_IDLE;
        endcase
    end

    // Sequencer registers
    // Result register keeps the last code until the next valid result
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= acam_pkg::ACAM_IDLE;
            edge_cnt_q <= 6'h00;
            conv_start_q <= 1'b0;
            conv_ch_q <= '0;
            result_q <= '0;
            alarm_q <= 1'b0;
        end else begin
            state_q <= state_d;
            edge_cnt_q <= edge_cnt_d;
            conv_start_q <= conv_start_d;
            conv_ch_q <= conv_ch_d;
            result_q <= result_d;
            alarm_q <= alarm_d;
        end
    end

    // New result re-evaluates only the converted channel
    // The result belongs to the channel latched at frame start
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            ch_eval[i] = result_valid && (conv_ch_q == acam_pkg::CH_W'(i));
        end
    end

    // Two alarms per channel, each with own threshold and hysteresis
    generate
        for (genvar g = 0; g < NCH; g++) begin : g_ch
            acam_chan_alarm #(.W(W)) u_alarm (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .eval(ch_eval[g]),
                .code(result_code),
                .hi_thresh(hi_thresh[g*W +: W]),
                .hi_hyst(hi_hyst[g*W +: W]),
                .lo_thresh(lo_thresh[g*W +: W]),
                .lo_hyst(lo_hyst[g*W +: W]),
                .hi_flag_q(hi_f[g]),
                .lo_flag_q(lo_f[g])
            );
        end
    endgenerate

    // Strap low selects internal reference, high external
    acam_pkg::acam_ref_t ref_sel;
    assign ref_sel = strap_s2_q ? acam_pkg::ACAM_REF_EXTERNAL
                                : acam_pkg::ACAM_REF_INTERNAL;

    // Outputs
    assign conv_start = conv_start_q;
    assign conv_channel = conv_ch_q;
    assign result_out = result_q;
    // Flags are read by the host after it sees the alarm pin high
    assign hi_flags = hi_f;
    assign lo_flags = lo_f;
    assign alarm = alarm_q;
    assign ref_external = strap_s2_q;
    // Reference pin driven only in internal mode
    assign reference_voltage_pin_oe = (ref_sel == acam_pkg::ACAM_REF_INTERNAL);
endmodule : acam_monitor

// ===== dv/acam_monitor_asserts.sv
// Port checker for the code alarm monitor
`timescale 1ns/10ps
module acam_monitor_asserts #(
    parameter int NCH = 4,
    parameter int W = 16
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic result_valid,
    input wire logic conv_start,
    input wire logic alarm,
    input wire logic [W-1:0] result_code,
    input wire logic [W-1:0] result_out,
    input wire logic [NCH*W-1:0] hi_thresh,
    input wire logic [NCH*W-1:0] hi_hyst,
    input wire logic [NCH*W-1:0] lo_thresh,
    input wire logic [NCH*W-1:0] lo_hyst,
    input wire logic [1:0] conv_channel,
    input wire logic [NCH-1:0] hi_flags,
    input wire logic [NCH-1:0] lo_flags
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Limits of the channel in conversion, as int so no bound wraps
    int cv, th, hh, tl, hl;
    assign cv = int'(result_code);
    assign th = int'(hi_thresh[conv_channel*W +: W]);
    assign hh = int'(hi_hyst[conv_channel*W +: W]);
    assign tl = int'(lo_thresh[conv_channel*W +: W]);
    assign hl = int'(lo_hyst[conv_channel*W +: W]);
    property p_res; result_valid |=> result_out == $past(result_code); endproperty
    a_res: assert property (p_res) else $error("result");
    property p_hs; result_valid && cv > th + hh |=> hi_flags[conv_channel]; endproperty
    a_hs: assert property (p_hs) else $error("hi set");
    property p_hc; result_valid && cv <= th - hh - 2 |=> !hi_flags[conv_channel]; endproperty
    a_hc: assert property (p_hc) else $error("hi clear");
    property p_hh;
        result_valid && cv > th - hh - 2 && cv <= th + hh |=> $stable(hi_flags);
    endproperty
    a_hh: assert property (p_hh) else $error("hi hold");
    property p_ls; result_valid && cv < tl - hl - 1 |=> lo_flags[conv_channel]; endproperty
    a_ls: assert property (p_ls) else $error("lo set");
    property p_lc; result_valid && cv >= tl + hl + 1 |=> !lo_flags[conv_channel]; endproperty
    a_lc: assert property (p_lc) else $error("lo clear");
    // Start is one pulse a few cycles after the select falls
    property p_st; $fell(cs_n) |-> ##[1:5] conv_start ##1 !conv_start; endproperty
    a_st: assert property (p_st) else $error("start");
    // Pin moves only inside a frame, while the serial clock is low
    property p_mv; $changed(alarm) |-> !cs_n && !sclk; endproperty
    a_mv: assert property (p_mv) else $error("alarm moved");
    c_al: cover property ($rose(alarm));
    c_ls: cover property (result_valid && cv < tl - hl - 1);
    c_st: cover property (conv_start);
endmodule : acam_monitor_asserts
bind acam_monitor acam_monitor_asserts #(
    .NCH(NCH),
    .W(W)
) u_chk (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .sclk(sclk),
    .cs_n(cs_n),
    .result_valid(result_valid),
    .conv_start(conv_start),
    .alarm(alarm),
    .result_code(result_code),
    .result_out(result_out),
    .hi_thresh(hi_thresh),
    .hi_hyst(hi_hyst),
    .lo_thresh(lo_thresh),
    .lo_hyst(lo_hyst),
    .conv_channel(conv_channel),
    .hi_flags(hi_flags),
    .lo_flags(lo_flags)
);

// ===== dv/acam_host_model.sv
// Host model: frames on the serial pins
`timescale 1ns/10ps
module acam_host_model (
    input wire logic ref_clk,
    output logic sclk = 1'b1,
    output logic cs_n = 1'b1
);
    // Clock still and high between frames; under 16 falls aborts
    task automatic frame(input int nf, input int hp);
        @(posedge ref_clk);
        #7 cs_n = 1'b0;
        repeat (nf) begin
            #(hp) sclk = 1'b0;
            #(hp) sclk = 1'b1;
        end
        #(hp) cs_n = 1'b1;
        #(hp);
    endtask : frame
endmodule : acam_host_model

// ===== dv/acam_monitor_test.sv
// Self-checking bench of the code alarm monitor
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module acam_monitor_test;
    logic ref_clk = 1'b0, rstn = 1'b0, result_valid = 1'b0, reference_source_strap = 1'b0;
    logic conv_start, alarm, ref_external, reference_voltage_pin_oe;
    logic [1:0] next_channel = 2'h0, conv_channel;
    logic [15:0] result_code = 16'h0000, result_out;
    logic [63:0] hi_thresh = {4{16'h03e8}}, hi_hyst = {4{16'h000a}};
    logic [63:0] lo_thresh = {4{16'h01f4}}, lo_hyst = {4{16'h0005}};
    logic [3:0] hi_flags, lo_flags;
    wire logic sclk, cs_n;
    int fail_count = 0, num_checks = 0;
    acam_monitor uut (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .sclk(sclk),
        .cs_n(cs_n),
        .next_channel(next_channel),
        .result_valid(result_valid),
        .result_code(result_code),
        .hi_thresh(hi_thresh),
        .hi_hyst(hi_hyst),
        .lo_thresh(lo_thresh),
        .lo_hyst(lo_hyst),
        .reference_source_strap(reference_source_strap),
        .conv_start(conv_start),
        .conv_channel(conv_channel),
        .result_out(result_out),
        .hi_flags(hi_flags),
        .lo_flags(lo_flags),
        .alarm(alarm),
        .ref_external(ref_external),
        .reference_voltage_pin_oe(reference_voltage_pin_oe)
    );
    acam_host_model hm (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n));
    initial forever #25 ref_clk = ~ref_clk;
    // Start pulses seen on the converter side; unknowns never count
    int starts = 0;
    always @(posedge ref_clk) begin
        if (conv_start === 1'b1) begin
            starts <= starts + 1;
        end
    end
    // Frame that picks channel ch; exactly one start per frame
    task automatic sel(input logic [1:0] ch, input int hp);
        int n;
        n = starts;
        @(posedge ref_clk);
        next_channel <= ch;
        hm.frame(16, hp);
        `CHK(conv_channel, ch)
        `CHK(starts, n + 1)
    endtask : sel
    // One result, then shown code and the channel's flags
    task automatic conv(input logic [15:0] c, input logic eh, input logic el);
        @(posedge ref_clk);
        result_valid <= 1'b1;
        result_code <= c;
        @(posedge ref_clk);
        result_valid <= 1'b0;
        repeat (2) @(negedge ref_clk);
        `CHK(result_out, c)
        `CHK(hi_flags[conv_channel], eh)
        `CHK(lo_flags[conv_channel], el)
    endtask : conv
    // High alarm edges; pin waits for a full frame
    task automatic t_high;
        sel(2'h2, 200);
        conv(16'h03f2, 1'b0, 1'b0);
        conv(16'h03f3, 1'b1, 1'b0);
        hm.frame(15, 200);
        `CHK(alarm, 1'b0)
        hm.frame(16, 200);
        `CHK(alarm, 1'b1)
        `CHK(hi_flags, 4'h4)
        conv(16'h03dd, 1'b1, 1'b0);
        conv(16'h03dc, 1'b0, 1'b0);
        `CHK(alarm, 1'b1)
        // Falls past the 16th must be ignored
        hm.frame(24, 200);
        `CHK(alarm, 1'b0)
        $display("t_high done");
    endtask : t_high
    // Low alarm edges on another channel
    task automatic t_low;
        sel(2'h1, 200);
        conv(16'h01ee, 1'b0, 1'b0);
        conv(16'h01ed, 1'b0, 1'b1);
        hm.frame(16, 200);
        `CHK(alarm, 1'b1)
        conv(16'h01f9, 1'b0, 1'b1);
        conv(16'h01fa, 1'b0, 1'b0);
        `CHK({hi_flags, lo_flags}, 8'h00)
        hm.frame(16, 200);
        `CHK(alarm, 1'b0)
        $display("t_low done");
    endtask : t_low
    // Strap picks the reference; a new limit on channel 3 is applied
    task automatic t_misc;
        @(posedge ref_clk);
        `CHK({ref_external, reference_voltage_pin_oe}, 2'h1)
        reference_source_strap <= 1'b1;
        hi_thresh[63:48] <= 16'h0100;
        repeat (5) @(posedge ref_clk);
        `CHK({ref_external, reference_voltage_pin_oe}, 2'h2)
        sel(2'h3, 200);
        // Code between the new and the old limit: only the new one trips
        conv(16'h0200, 1'b1, 1'b0);
        conv(16'h0000, 1'b0, 1'b1);
        $display("t_misc done");
    endtask : t_misc
    // Counts, verdict, end of run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    initial begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_high();
        t_low();
        t_misc();
        stop_test();
    end
    // Watchdog well beyond the expected run
    initial begin
        #1000000;
        fail_count++;
        stop_test();
    end
endmodule : acam_monitor_test
